// *** rtl/pscr_fault_react.sv ***
// combines monitor faults with their two-bit reaction fields into reset and safe-state requests
// assumes fault inputs are synchronous levels; result is combinational, registered by the caller
`timescale 1ns/1ns
module pscr_fault_react #(
   parameter int N = 7
) (
   input logic [N-1:0] i_uv,
   input logic [N-1:0] i_ov,
   input logic [2*N-1:0] i_uv_code,
   input logic [2*N-1:0] i_ov_code,
   output logic o_rst,
   output logic o_safe
);

   always_comb begin
      pscr_pkg::pscr_react_t u;
      pscr_pkg::pscr_react_t o;
      u = '{rst: 1'b0, safe: 1'b0};
      o = '{rst: 1'b0, safe: 1'b0};
      o_rst = 1'b0;
      o_safe = 1'b0;
      for (int k = 0; k < N; k++) begin
         u = pscr_pkg::decode_reaction(i_uv_code[2*k +: 2], i_uv[k]); // [RQ14] [RQ16]
         o = pscr_pkg::decode_reaction(i_ov_code[2*k +: 2], i_ov[k]); // [RQ14]
         o_rst = o_rst | u.rst | o.rst;
         o_safe = o_safe | u.safe | o.safe;
      end
   end

endmodule : pscr_fault_react

// *** rtl/pscr_pkg.sv ***
// constants, field layout and carrier types of the power-management status and configuration register bank
// assumes a 16-bit register word whose bit 0 is the device's BIT8 position
package pscr_pkg;

   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;
   localparam int N_MON = 7;

   // register indexes on the decoded register port
   localparam logic [3:0] ADDR_SCALE_OFFSET = 4'h0;
   localparam logic [3:0] ADDR_STANDBY_VOLT = 4'h1;
   localparam logic [3:0] ADDR_SCRATCH0 = 4'h2;
   localparam logic [3:0] ADDR_SCRATCH1 = 4'h3;
   localparam logic [3:0] ADDR_IDENT = 4'h4;
   localparam logic [3:0] ADDR_GROUP_FLAGS = 4'h5;
   localparam logic [3:0] ADDR_REACT_A = 4'h6;
   localparam logic [3:0] ADDR_REACT_B = 4'h7;

   // scale offset: 6250 uV per code, 0 to 793750 uV
   localparam int SCALE_OFFSET_W = 7;
   localparam int STANDBY_VOLT_W = 8;
   localparam int REACT_A_W = 12;

   // identification word layout
   localparam int ID_DEV_LSB = 0;
   localparam int ID_FAM_LSB = 4;
   localparam int ID_METAL_REV_LSB = 8;
   localparam int ID_FULL_MASK_REV_LSB = 12;

   // group flag bit positions
   localparam int FLG_FAULT_B = 8;
   localparam int FLG_FAULT_A = 9;
   localparam int FLG_WAKE = 10;
   localparam int FLG_WINDOW = 11;
   localparam int FLG_MON_G = 12;
   localparam int FLG_PIN_G = 13;
   localparam int FLG_WD_G = 14;
   localparam int FLG_COMM_G = 15;

   // monitor order in the fault vectors; reaction fields sit in this order, uv then ov
   localparam int MON_IO = 0;
   localparam int MON_HV_LINEAR = 1;
   localparam int MON_CORE = 2;
   localparam int MON_GEN1 = 3;

   localparam logic [6:0] SCALE_OFFSET_RST = 7'h00;
   localparam logic [7:0] STANDBY_VOLT_RST = 8'h00;
   localparam logic [15:0] SCRATCH_RST = 16'h0000;
   localparam logic [11:0] REACT_A_RST = 12'h999;
   localparam logic [15:0] REACT_B_RST = 16'h9999;

   typedef enum logic [1:0] {
      ACT_NONE = 2'b00,
      ACT_SAFE_ONLY = 2'b01,
      ACT_BOTH = 2'b10,
      ACT_BOTH_ALT = 2'b11
   } pscr_action_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } pscr_reg_req_t;

   typedef struct packed {
      logic rst;
      logic safe;
   } pscr_react_t;

   function automatic pscr_react_t decode_reaction(input logic [1:0] code, input logic fault);
      pscr_react_t r;
      r = '{rst: 1'b0, safe: 1'b0};
      if (fault) begin
         unique case (pscr_action_t'(code))
            ACT_NONE: r = '{rst: 1'b0, safe: 1'b0};
            ACT_SAFE_ONLY: r = '{rst: 1'b0, safe: 1'b1};
            ACT_BOTH, ACT_BOTH_ALT: r = '{rst: 1'b1, safe: 1'b1};
         endcase
      end
      return r;
   endfunction : decode_reaction

endpackage : pscr_pkg

// *** rtl/pscr_pkg_unused_guard.sv ***
// holds no module: the bank and its two leaves are defined elsewhere
// assumes nothing of its surroundings

// *** rtl/pscr_regs.sv ***
// register bank of the power-management device: buck settings, scratch, identity,
// group flags and monitor fault reactions driving the reset and safe-state outputs
// assumes a serial-bus engine outside that hands over decoded one-cycle register strobes
// Operation
// RQ1: seven-bit core buck scaling offset, 6.25 mV steps, cleared at reset
// RQ2: eight-bit core buck standby voltage, codes map 0.4 V to 1.8 V
// RQ3: standby voltage default comes from one-time-programmable configuration
// RQ4: two sixteen-bit scratch words, read-write, cleared at reset
// RQ5: read-only identity word: device, family, full-mask and metal revision codes
// RQ6: live levels of both fault-collection inputs readable as status bits
// RQ7: wake flag set on start from standby, zero after cold start
// RQ8: standby window error flag latches until cleared
// RQ9: wake and window flags clear on write of one, and at reset
// RQ10: monitor group bit sets on any uv or ov fault, reset clears
// RQ11: safety pin group bit is OR of three pin diagnostics
// RQ12: watchdog group bit set on bad refresh, zero while refreshes good
// RQ13: comm group bit set on host serial communication error
// RQ14: reaction code 00 none, 01 safe only, 10 or 11 both outputs
// RQ15: separate uv and ov reaction fields for io, hv linear, core monitors
// RQ16: hv linear regulator uv applies configured reaction, 1x asserts both
// RQ17: second reaction register holds four general monitors, bits 8 to 23
// RQ18: writing zero to flags, or read-only bits, changes nothing
// RQ19: host clears all flags after start-up by writing ones; a write of ones clears only wake and window, group bits are read-only
`timescale 1ns/1ns
module pscr_regs #(
   // identity codes; the default values are arbitrary
   parameter logic [3:0] DEVICE_CODE = 4'ha,
   parameter logic [3:0] FAMILY_CODE = 4'h5,
   parameter logic [2:0] METAL_REVISION = 3'h0,
   parameter logic [2:0] FULL_MASK_REVISION = 3'h0,
   parameter int N_MON = 7
) (
   input logic I_CLK_SYS,
   input logic I_RESET_N,
   input pscr_pkg::pscr_reg_req_t I_REG_REQ,
   output logic [15:0] O_REG_RDATA,
   output logic O_REG_RVALID,
   input logic [7:0] I_OTP_STANDBY_VOLTAGE,
   input logic I_FAULT_INPUT_A,
   input logic I_FAULT_INPUT_B,
   input logic I_STANDBY_WAKE,
   input logic I_STANDBY_WINDOW_ERR,
   input logic [N_MON-1:0] I_MON_UV,
   input logic [N_MON-1:0] I_MON_OV,
   input logic I_POWER_GOOD_DIAG,
   input logic I_RESET_PIN_DIAG,
   input logic I_SAFE_OUT_DIAG,
   input logic I_WD_REFRESH_BAD,
   input logic I_WD_REFRESH_GOOD,
   input logic I_COMM_ERR,
   output logic [6:0] O_CORE_BUCK_SCALE_OFFSET,
   output logic [7:0] O_CORE_BUCK_STANDBY_VOLTAGE,
   output logic O_RESET_OUT_N,
   output logic O_SAFE_STATE_OUT_N
);

   logic [6:0] scale_offset_reg;
   logic [7:0] standby_volt_reg;
   logic otp_loaded_reg;
   logic [15:0] scratch0_reg;
   logic [15:0] scratch1_reg;
   logic [11:0] react_a_reg;
   logic [15:0] react_b_reg;
   logic mon_group_reg;
   logic pin_group_reg;
   logic wd_group_reg;
   logic comm_group_reg;
   logic wake_flag;
   logic window_flag;
   logic [15:0] rdata_reg;
   logic [15:0] rdata_next;
   logic rvalid_reg;
   logic rst_req;
   logic safe_req;
   logic reset_out_n_reg;
   logic safe_out_n_reg;
   logic [15:0] ident_word;
   logic [2*N_MON-1:0] uv_codes;
   logic [2*N_MON-1:0] ov_codes;

   function automatic logic wr_hit(input pscr_pkg::pscr_reg_req_t req, input logic [3:0] addr);
      return req.wr && (req.addr == addr);
   endfunction : wr_hit

   // scaling offset; upper bits of the word are reserved
   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RESET_N) begin
         scale_offset_reg <= pscr_pkg::SCALE_OFFSET_RST;
      end else if (wr_hit(I_REG_REQ, pscr_pkg::ADDR_SCALE_OFFSET)) begin
         scale_offset_reg <= I_REG_REQ.wdata[6:0]; // [RQ1] [RQ18]
      end
   end

   // standby voltage takes the programmed default in the first cycle after reset release,
   // since a reset must load only a constant; a write in that same cycle is lost
   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RESET_N) begin
         standby_volt_reg <= pscr_pkg::STANDBY_VOLT_RST;
         otp_loaded_reg <= 1'b0;
      end else if (!otp_loaded_reg) begin
         standby_volt_reg <= I_OTP_STANDBY_VOLTAGE; // [RQ3]
         otp_loaded_reg <= 1'b1;
      end else if (wr_hit(I_REG_REQ, pscr_pkg::ADDR_STANDBY_VOLT)) begin
         standby_volt_reg <= I_REG_REQ.wdata[7:0]; // [RQ2]
      end
   end

   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RESET_N) begin
         scratch0_reg <= pscr_pkg::SCRATCH_RST;
         scratch1_reg <= pscr_pkg::SCRATCH_RST;
      end else begin
         if (wr_hit(I_REG_REQ, pscr_pkg::ADDR_SCRATCH0)) begin
            scratch0_reg <= I_REG_REQ.wdata; // [RQ4]
         end
         if (wr_hit(I_REG_REQ, pscr_pkg::ADDR_SCRATCH1)) begin
            scratch1_reg <= I_REG_REQ.wdata; // [RQ4]
         end
      end
   end

   // reaction fields: uv and ov per monitor, io, hv linear and core in word a
   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RESET_N) begin
         react_a_reg <= pscr_pkg::REACT_A_RST;
         react_b_reg <= pscr_pkg::REACT_B_RST;
      end else begin
         if (wr_hit(I_REG_REQ, pscr_pkg::ADDR_REACT_A)) begin
            react_a_reg <= I_REG_REQ.wdata[11:0]; // [RQ15]
         end
         if (wr_hit(I_REG_REQ, pscr_pkg::ADDR_REACT_B)) begin
            react_b_reg <= I_REG_REQ.wdata; // [RQ17]
         end
      end
   end

   // fields sit as uv/ov pairs per monitor; split them into two code vectors
   always_comb begin
      uv_codes = '0;
      ov_codes = '0;
      // two loops keep every part-select inside its own word
      for (int k = 0; k < pscr_pkg::MON_GEN1; k++) begin
         uv_codes[2*k +: 2] = react_a_reg[4*k +: 2];
         ov_codes[2*k +: 2] = react_a_reg[4*k+2 +: 2];
      end
      for (int k = pscr_pkg::MON_GEN1; k < N_MON; k++) begin
         uv_codes[2*k +: 2] = react_b_reg[4*(k-pscr_pkg::MON_GEN1) +: 2]; // [RQ17]
         ov_codes[2*k +: 2] = react_b_reg[4*(k-pscr_pkg::MON_GEN1)+2 +: 2];
      end
   end

   pscr_fault_react #(
      .N(N_MON)
   ) u_react (
      .i_uv(I_MON_UV),
      .i_ov(I_MON_OV),
      .i_uv_code(uv_codes),
      .i_ov_code(ov_codes),
      .o_rst(rst_req),
      .o_safe(safe_req)
   );

   // outputs follow the fault level; latching and pulse length belong to the safety state machine
   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RESET_N) begin
         reset_out_n_reg <= 1'b1;
         safe_out_n_reg <= 1'b1;
      end else begin
         reset_out_n_reg <= !rst_req; // [RQ14] [RQ16]
         safe_out_n_reg <= !safe_req; // [RQ14]
      end
   end

   pscr_w1c_flag u_wake (
      .i_clk(I_CLK_SYS),
      .i_reset_n(I_RESET_N),
      .i_set(I_STANDBY_WAKE), // [RQ7]
      .i_clear(wr_hit(I_REG_REQ, pscr_pkg::ADDR_GROUP_FLAGS) && I_REG_REQ.wdata[pscr_pkg::FLG_WAKE]), // [RQ9]
      .o_flag(wake_flag)
   );

   pscr_w1c_flag u_window (
      .i_clk(I_CLK_SYS),
      .i_reset_n(I_RESET_N),
      .i_set(I_STANDBY_WINDOW_ERR), // [RQ8]
      .i_clear(wr_hit(I_REG_REQ, pscr_pkg::ADDR_GROUP_FLAGS) && I_REG_REQ.wdata[pscr_pkg::FLG_WINDOW]), // [RQ9]
      .o_flag(window_flag)
   );

   // group bits: none of them is writable
   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RESET_N) begin
         mon_group_reg <= 1'b0;
      end else if (|I_MON_UV || |I_MON_OV) begin
         mon_group_reg <= 1'b1; // [RQ10]
      end
   end

   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RESET_N) begin
         pin_group_reg <= 1'b0;
      end else begin
         pin_group_reg <= I_POWER_GOOD_DIAG | I_RESET_PIN_DIAG | I_SAFE_OUT_DIAG; // [RQ11]
      end
   end

   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RESET_N) begin
         wd_group_reg <= 1'b0;
      end else if (I_WD_REFRESH_BAD) begin
         wd_group_reg <= 1'b1; // [RQ12]
      end else if (I_WD_REFRESH_GOOD) begin
         wd_group_reg <= 1'b0; // [RQ12]
      end
   end

   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RESET_N) begin
         comm_group_reg <= 1'b0;
      end else if (I_COMM_ERR) begin
         comm_group_reg <= 1'b1; // [RQ13]
      end
   end

   always_comb begin
      ident_word = '0;
      ident_word[pscr_pkg::ID_DEV_LSB +: 4] = DEVICE_CODE; // [RQ5]
      ident_word[pscr_pkg::ID_FAM_LSB +: 4] = FAMILY_CODE;
      ident_word[pscr_pkg::ID_METAL_REV_LSB +: 3] = METAL_REVISION;
      ident_word[pscr_pkg::ID_FULL_MASK_REV_LSB +: 3] = FULL_MASK_REVISION;
   end

   // read mux; unmapped indexes and reserved bits read zero
   always_comb begin
      rdata_next = '0;
      unique case (I_REG_REQ.addr)
         pscr_pkg::ADDR_SCALE_OFFSET: rdata_next[6:0] = scale_offset_reg;
         pscr_pkg::ADDR_STANDBY_VOLT: rdata_next[7:0] = standby_volt_reg;
         pscr_pkg::ADDR_SCRATCH0: rdata_next = scratch0_reg;
         pscr_pkg::ADDR_SCRATCH1: rdata_next = scratch1_reg;
         pscr_pkg::ADDR_IDENT: rdata_next = ident_word; // [RQ5]
         pscr_pkg::ADDR_GROUP_FLAGS: begin
            rdata_next[pscr_pkg::FLG_FAULT_B] = I_FAULT_INPUT_B; // [RQ6]
            rdata_next[pscr_pkg::FLG_FAULT_A] = I_FAULT_INPUT_A; // [RQ6]
            rdata_next[pscr_pkg::FLG_WAKE] = wake_flag;
            rdata_next[pscr_pkg::FLG_WINDOW] = window_flag;
            rdata_next[pscr_pkg::FLG_MON_G] = mon_group_reg;
            rdata_next[pscr_pkg::FLG_PIN_G] = pin_group_reg;
            rdata_next[pscr_pkg::FLG_WD_G] = wd_group_reg;
            rdata_next[pscr_pkg::FLG_COMM_G] = comm_group_reg;
         end
         pscr_pkg::ADDR_REACT_A: rdata_next[11:0] = react_a_reg;
         pscr_pkg::ADDR_REACT_B: rdata_next = react_b_reg;
         default: rdata_next = '0;
      endcase
   end

   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RESET_N) begin
         rdata_reg <= '0;
         rvalid_reg <= 1'b0;
      end else begin
         rvalid_reg <= I_REG_REQ.rd;
         if (I_REG_REQ.rd) begin
            rdata_reg <= rdata_next;
         end
      end
   end

   assign O_REG_RDATA = rdata_reg;
   assign O_REG_RVALID = rvalid_reg;
   assign O_CORE_BUCK_SCALE_OFFSET = scale_offset_reg;
   assign O_CORE_BUCK_STANDBY_VOLTAGE = standby_volt_reg;
   assign O_RESET_OUT_N = reset_out_n_reg;
   assign O_SAFE_STATE_OUT_N = safe_out_n_reg;

   property p_scale_write;
      @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
      wr_hit(I_REG_REQ, pscr_pkg::ADDR_SCALE_OFFSET) |=> O_CORE_BUCK_SCALE_OFFSET == $past(I_REG_REQ.wdata[6:0]);
   endproperty
   a_scale_write: assert property (p_scale_write) else $error("scale offset not written"); // [RQ1]

   property p_otp_load;
      @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
      (otp_loaded_reg && !$past(otp_loaded_reg)) |-> standby_volt_reg == $past(I_OTP_STANDBY_VOLTAGE);
   endproperty
   a_otp_load: assert property (p_otp_load) else $error("standby default not loaded"); // [RQ3]

   property p_scratch_hold;
      @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
      wr_hit(I_REG_REQ, pscr_pkg::ADDR_SCRATCH1) ##1 !wr_hit(I_REG_REQ, pscr_pkg::ADDR_SCRATCH1)
         |=> scratch1_reg == $past(I_REG_REQ.wdata, 2);
   endproperty
   a_scratch_hold: assert property (p_scratch_hold) else $error("scratch word not kept"); // [RQ4]

   property p_ident_read;
      @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
      (I_REG_REQ.rd && I_REG_REQ.addr == pscr_pkg::ADDR_IDENT) |=>
         O_REG_RVALID && O_REG_RDATA[3:0] == DEVICE_CODE && O_REG_RDATA[7:4] == FAMILY_CODE && !O_REG_RDATA[15];
   endproperty
   a_ident_read: assert property (p_ident_read) else $error("identity word wrong"); // [RQ5]

   property p_live_inputs;
      @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
      (I_REG_REQ.rd && I_REG_REQ.addr == pscr_pkg::ADDR_GROUP_FLAGS) |=>
         O_REG_RDATA[9:8] == {$past(I_FAULT_INPUT_A), $past(I_FAULT_INPUT_B)};
   endproperty
   a_live_inputs: assert property (p_live_inputs) else $error("fault input levels misreported"); // [RQ6]

   property p_zero_write_keeps;
      @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
      (wake_flag && wr_hit(I_REG_REQ, pscr_pkg::ADDR_GROUP_FLAGS) && !I_REG_REQ.wdata[pscr_pkg::FLG_WAKE]) |=> wake_flag;
   endproperty
   a_zero_write_keeps: assert property (p_zero_write_keeps) else $error("zero write cleared wake flag"); // [RQ18]

   property p_window_clear;
      @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
      (wr_hit(I_REG_REQ, pscr_pkg::ADDR_GROUP_FLAGS) && I_REG_REQ.wdata[pscr_pkg::FLG_WINDOW] && !I_STANDBY_WINDOW_ERR)
         |=> !window_flag;
   endproperty
   a_window_clear: assert property (p_window_clear) else $error("window flag not cleared"); // [RQ9]

   property p_mon_group_sticky;
      @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
      (|I_MON_UV || |I_MON_OV) |=> mon_group_reg [*3];
   endproperty
   a_mon_group_sticky: assert property (p_mon_group_sticky) else $error("monitor group bit not sticky"); // [RQ10]

   property p_pin_group;
      @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
      ##1 pin_group_reg == $past(I_POWER_GOOD_DIAG | I_RESET_PIN_DIAG | I_SAFE_OUT_DIAG);
   endproperty
   a_pin_group: assert property (p_pin_group) else $error("pin group bit wrong"); // [RQ11]

   property p_wd_group;
      @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
      (I_WD_REFRESH_GOOD && !I_WD_REFRESH_BAD) |=> !wd_group_reg;
   endproperty
   a_wd_group: assert property (p_wd_group) else $error("watchdog group stuck after good refresh"); // [RQ12]

   property p_hv_uv_both;
      @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
      (I_MON_UV[pscr_pkg::MON_HV_LINEAR] && react_a_reg[5]) |=> !O_RESET_OUT_N && !O_SAFE_STATE_OUT_N;
   endproperty
   a_hv_uv_both: assert property (p_hv_uv_both) else $error("hv linear uv reaction missing"); // [RQ16]

   property p_no_fault_no_action;
      @(posedge I_CLK_SYS) disable iff (!I_RESET_N)
      (!(|I_MON_UV) && !(|I_MON_OV)) |=> O_RESET_OUT_N && O_SAFE_STATE_OUT_N;
   endproperty
   a_no_fault_no_action: assert property (p_no_fault_no_action) else $error("output asserted without fault"); // [RQ14]

endmodule : pscr_regs

// *** rtl/pscr_w1c_flag.sv ***
// one sticky status flag: hardware sets, software clears by writing one
// assumes set and clear are one-cycle strobes on the system clock
`timescale 1ns/1ns
module pscr_w1c_flag (
   input logic i_clk,
   input logic i_reset_n,
   input logic i_set,
   input logic i_clear,
   output logic o_flag
);

   always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
         o_flag <= 1'b0;
      end else if (i_set) begin
         // set wins so an event coinciding with the clear is kept
         o_flag <= 1'b1;
      end else if (i_clear) begin
         o_flag <= 1'b0;
      end
   end

   property p_flag_set_wins;
      @(posedge i_clk) disable iff (!i_reset_n)
      i_set |=> o_flag;
   endproperty
   a_flag_set_wins: assert property (p_flag_set_wins) else $error("flag lost a set event"); // [RQ9]

endmodule : pscr_w1c_flag

// *** tb/pscr_host_model.sv ***
// host side of the register port: issues one-cycle write and read strobes
// assumes the bank answers a read with a one-cycle valid one edge after the strobe
`timescale 1ns/1ns
module pscr_host_model (
   input wire logic i_clk,
   input wire logic [15:0] i_rdata,
   input wire logic i_rvalid,
   output pscr_pkg::pscr_reg_req_t o_req
);
   initial o_req = '0;

   task automatic write_reg(input logic [3:0] addr, input logic [15:0] data);
      @(posedge i_clk);
      o_req <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
      @(posedge i_clk);
      o_req <= '0;
   endtask : write_reg

   task automatic read_reg(input logic [3:0] addr, output logic [15:0] data, output bit ok);
      ok = 1'b0;
      data = '0;
      @(posedge i_clk);
      o_req <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 16'h0000};
      @(posedge i_clk);
      o_req <= '0;
      // bounded wait so a silent bank cannot hang the host
      for (int i = 0; i < 4 && !ok; i++) begin
         @(negedge i_clk);
         if (i_rvalid === 1'b1) begin
            ok = 1'b1;
            data = i_rdata;
         end
      end
   endtask : read_reg

   task automatic clear_flags;
      write_reg(pscr_pkg::ADDR_GROUP_FLAGS, 16'h0c00);
   endtask : clear_flags
endmodule : pscr_host_model

// *** tb/testbench.sv ***
// self-checking bench for the power-management register bank
// assumes the host model owns the register port; every other input is driven here
`timescale 1ns/1ns
module testbench;
   localparam logic [3:0] FLG = pscr_pkg::ADDR_GROUP_FLAGS;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   pscr_pkg::pscr_reg_req_t reg_req;
   logic [15:0] rdata;
   logic rvalid;
   logic [7:0] otp = 8'h5a;
   logic fault_a = 1'b0;
   logic fault_b = 1'b0;
   // pulse bits: wake, window error, wd bad, wd good, comm error
   logic [4:0] pul = '0;
   logic [6:0] mon_uv = '0;
   logic [6:0] mon_ov = '0;
   logic [2:0] diag = '0;
   logic [6:0] scale;
   logic [7:0] stby;
   logic rst_out_n;
   logic safe_out_n;
   logic [15:0] d;
   logic [15:0] fv;
   int p;
   int error_cnt = 0;
   int n_checks = 0;

   always #50 clk_sys = ~clk_sys;

   pscr_host_model host (.i_clk(clk_sys), .i_rdata(rdata), .i_rvalid(rvalid), .o_req(reg_req));

   // identity values are arbitrary
   pscr_regs #(.DEVICE_CODE(4'h3), .FAMILY_CODE(4'hc), .METAL_REVISION(3'h5), .FULL_MASK_REVISION(3'h2),
      .N_MON(7)) DUT (
      .I_CLK_SYS(clk_sys), .I_RESET_N(reset_n), .I_REG_REQ(reg_req), .O_REG_RDATA(rdata),
      .O_REG_RVALID(rvalid), .I_OTP_STANDBY_VOLTAGE(otp), .I_FAULT_INPUT_A(fault_a),
      .I_FAULT_INPUT_B(fault_b), .I_STANDBY_WAKE(pul[0]), .I_STANDBY_WINDOW_ERR(pul[1]),
      .I_MON_UV(mon_uv), .I_MON_OV(mon_ov), .I_POWER_GOOD_DIAG(diag[0]), .I_RESET_PIN_DIAG(diag[1]),
      .I_SAFE_OUT_DIAG(diag[2]), .I_WD_REFRESH_BAD(pul[2]), .I_WD_REFRESH_GOOD(pul[3]),
      .I_COMM_ERR(pul[4]), .O_CORE_BUCK_SCALE_OFFSET(scale), .O_CORE_BUCK_STANDBY_VOLTAGE(stby),
      .O_RESET_OUT_N(rst_out_n), .O_SAFE_STATE_OUT_N(safe_out_n));

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : report_and_stop

   task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk16

   task automatic chk1(input logic got, input logic exp, input string what);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: %s got %b expected %b", $time, what, got, exp);
      end
   endtask : chk1

   task automatic rd_chk(input logic [3:0] addr, input logic [15:0] exp);
      bit ok;
      host.read_reg(addr, d, ok);
      if (!ok) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: no read answer", $time);
         report_and_stop();
      end else begin
         chk16(d, exp, "read data");
      end
   endtask : rd_chk

   task automatic pulse(input int i);
      @(posedge clk_sys);
      pul <= 5'h01 << i;
      @(posedge clk_sys);
      pul <= '0;
   endtask : pulse

   // outputs are level-following: drop the fault and let them recover before the next case
   task automatic fault(input int m, input bit ov, input logic [1:0] c);
      @(posedge clk_sys);
      if (ov) begin
         mon_ov[m] <= 1'b1;
      end else begin
         mon_uv[m] <= 1'b1;
      end
      @(posedge clk_sys);
      @(negedge clk_sys);
      chk1(rst_out_n, ~c[1], "reset out");
      chk1(safe_out_n, c == 2'b00, "safe out");
      @(posedge clk_sys);
      mon_uv <= '0;
      mon_ov <= '0;
      repeat (2) @(posedge clk_sys);
   endtask : fault

   initial begin
      repeat (5) @(posedge clk_sys);
      reset_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rd_chk(pscr_pkg::ADDR_SCALE_OFFSET, 16'h0000);
      rd_chk(pscr_pkg::ADDR_STANDBY_VOLT, 16'h005a);
      rd_chk(pscr_pkg::ADDR_SCRATCH0, 16'h0000);
      rd_chk(pscr_pkg::ADDR_SCRATCH1, 16'h0000);
      rd_chk(pscr_pkg::ADDR_IDENT, 16'h25c3);
      rd_chk(FLG, 16'h0000);
      rd_chk(pscr_pkg::ADDR_REACT_A, 16'h0999);
      rd_chk(pscr_pkg::ADDR_REACT_B, 16'h9999);
      $display("test reset values done");
      host.write_reg(pscr_pkg::ADDR_SCALE_OFFSET, 16'hffff);
      rd_chk(pscr_pkg::ADDR_SCALE_OFFSET, 16'h007f);
      chk16({9'h000, scale}, 16'h007f, "scale out");
      host.write_reg(pscr_pkg::ADDR_STANDBY_VOLT, 16'hff80);
      rd_chk(pscr_pkg::ADDR_STANDBY_VOLT, 16'h0080);
      chk16({8'h00, stby}, 16'h0080, "standby out");
      host.write_reg(pscr_pkg::ADDR_SCRATCH0, 16'ha5c3);
      host.write_reg(pscr_pkg::ADDR_SCRATCH1, 16'h5a3c);
      rd_chk(pscr_pkg::ADDR_SCRATCH0, 16'ha5c3);
      rd_chk(pscr_pkg::ADDR_SCRATCH1, 16'h5a3c);
      host.write_reg(pscr_pkg::ADDR_IDENT, 16'hffff);
      rd_chk(pscr_pkg::ADDR_IDENT, 16'h25c3);
      host.write_reg(4'h8, 16'hffff);
      rd_chk(4'h8, 16'h0000);
      $display("test register access done");
      @(posedge clk_sys);
      fault_a <= 1'b1;
      rd_chk(FLG, 16'h0200);
      @(posedge clk_sys);
      fault_a <= 1'b0;
      fault_b <= 1'b1;
      rd_chk(FLG, 16'h0100);
      @(posedge clk_sys);
      fault_b <= 1'b0;
      pulse(0);
      rd_chk(FLG, 16'h0400);
      pulse(1);
      rd_chk(FLG, 16'h0c00);
      host.write_reg(FLG, 16'hf3ff);
      rd_chk(FLG, 16'h0c00);
      host.write_reg(FLG, 16'h0400);
      rd_chk(FLG, 16'h0800);
      host.clear_flags();
      rd_chk(FLG, 16'h0000);
      pulse(0);
      @(posedge clk_sys);
      otp <= 8'ha7;
      reset_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      reset_n <= 1'b1;
      repeat (2) @(posedge clk_sys);
      rd_chk(FLG, 16'h0000);
      rd_chk(pscr_pkg::ADDR_STANDBY_VOLT, 16'h00a7);
      rd_chk(pscr_pkg::ADDR_SCALE_OFFSET, 16'h0000);
      $display("test status flags done");
      for (int i = 0; i < 3; i++) begin
         @(posedge clk_sys);
         diag <= 3'b001 << i;
         rd_chk(FLG, 16'h2000);
      end
      @(posedge clk_sys);
      diag <= '0;
      rd_chk(FLG, 16'h0000);
      pulse(2);
      rd_chk(FLG, 16'h4000);
      pulse(3);
      rd_chk(FLG, 16'h0000);
      pulse(4);
      rd_chk(FLG, 16'h8000);
      $display("test group bits done");
      for (int m = 0; m < 7; m++) begin
         for (int c = 0; c < 4; c++) begin
            p = (m < 3) ? 4 * m : 4 * (m - 3);
            fv = 16'({2'(3 - c), 2'(c)}) << p;
            host.write_reg(pscr_pkg::ADDR_REACT_A, (m < 3) ? fv : 16'h0000);
            host.write_reg(pscr_pkg::ADDR_REACT_B, (m < 3) ? 16'h0000 : fv);
            rd_chk((m < 3) ? pscr_pkg::ADDR_REACT_A : pscr_pkg::ADDR_REACT_B, fv);
            fault(m, 1'b0, 2'(c));
            fault(m, 1'b1, 2'(3 - c));
         end
      end
      rd_chk(FLG, 16'h9000);
      $display("test fault reactions done");
      report_and_stop();
   end
endmodule : testbench
